//--- src/pics_pkg.sv
// Shared constants and types of the paged control-port slave.
package pics_pkg;
  localparam logic [6:0] LOC_PAGE = 7'h00;
  localparam logic [6:0] LOC_LAST = 7'h7F;
  localparam logic [6:0] LOC_STEP = 7'h01;
  localparam logic [7:0] PAGE0_VAL = 8'h00;
  localparam logic [7:0] PAGE1_VAL = 8'h01;
  localparam logic [6:0] GCALL_ADDR = 7'h00;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [2:0] BIT_STEP = 3'h1;
  localparam logic [2:0] SYNC_IDLE = 3'h7;
  localparam logic PART_A = 1'b0;
  localparam logic PART_B = 1'b1;
  localparam logic DIR_READ = 1'b1;

  typedef enum logic [2:0] {
    S_IDLE,
    S_ADDR,
    S_ACK,
    S_WRITE,
    S_READ,
    S_RACK,
    S_WAIT
  } pics_state_type;
endpackage

//--- src/pics_slave.sv
// Two-identity paged register slave on a two-wire control bus.
// Overview of operation
// - Two slave addresses, one per partition.
// - Each identity has pages of 128 locations.
// - Location 0 selects the active page.
// - Locations 1 to 127 reach selected page.
// - Pages 0 and 1 only; reset selects 0.
// - Value 01h selects page 1, 00h page 0.
// - Seven-bit addressing only, standard and fast.
// - Strap input adjusts each partition address.
// - Never drive SCL; SDA only pulled low.
// - START and STOP from SDA while SCL high.
// - Eight-bit units, bits sampled on SCL high.
// - Acknowledge each received byte on ninth clock.
// - Unmatched address leaves SDA released.
// - START on an active bus restarts addressing.
// - Acknowledge the general call address 00h.
// - Write bursts store to next higher location.
// - Acknowledged read sends next higher location.
// - Auto-increment never leaves the page.
`timescale 1ns/1ps
`default_nettype none
module pics_slave #(
  // Base addresses are arbitrary; bit 0 is ORed with the strap.
  parameter logic [6:0] ADDR_A_BASE = 7'h20,
  parameter logic [6:0] ADDR_B_BASE = 7'h22
) (
  input wire logic CLK,
  input wire logic ARST_N,
  input wire logic RESET_A_N,
  input wire logic RESET_B_N,
  input wire logic ADDR_A,
  input wire logic ADDR_B,
  input wire logic SCL,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE,
  output logic REG_WR,
  output logic REG_RD,
  output logic REG_PART,
  output logic REG_PAGE,
  output logic [6:0] REG_ADDR,
  output logic [7:0] REG_WDATA,
  input wire logic [7:0] REG_RDATA
);
  // ==========================================================
  // State
  typedef struct packed {
    pics_pkg::pics_state_type st;
    logic [2:0] scl_s, sda_s, ra_s, rb_s, aa_s, ab_s;
    logic scl_f, sda_f, ra_f, rb_f, strap_a, strap_b;
    logic [2:0] cnt;
    logic done;
    logic [7:0] sh;
    logic part, gcall, rw, ptr_load, rd_pend;
    logic [1:0] page;
    logic [1:0][6:0] ptr;
    logic sda_oe, sda_out, reg_wr, reg_rd, reg_part, reg_page;
    logic [6:0] reg_addr;
    logic [7:0] reg_wdata;
  } pics_regs_type;

  pics_regs_type q, next_q;

  // ==========================================================
  // Helpers
  // A change counts once the second and third stages agree.
  function automatic logic flt(input logic [2:0] s, input logic f);
    return (s[1] == s[2]) ? s[2] : f;
  endfunction
  function automatic logic [6:0] inc_sat(input logic [6:0] a);
    return (a == pics_pkg::LOC_LAST) ? a : a + pics_pkg::LOC_STEP;
  endfunction
  function automatic logic [6:0] addr_of(input logic [6:0] base,
                                         input logic strap);
    return base | 7'(strap);
  endfunction

  logic scl_n, sda_n, scl_rise, scl_fall, start, stop, hit_a, hit_b, gc;
  logic [6:0] cur_ptr;

  assign scl_n = flt(q.scl_s, q.scl_f);
  assign sda_n = flt(q.sda_s, q.sda_f);
  assign scl_rise = !q.scl_f && scl_n;
  assign scl_fall = q.scl_f && !scl_n;
  assign start = q.scl_f && scl_n && q.sda_f && !sda_n;
  assign stop = q.scl_f && scl_n && !q.sda_f && sda_n;
  assign hit_a = q.ra_f && q.sh[7:1] == addr_of(ADDR_A_BASE, q.strap_a);
  assign hit_b = q.rb_f && q.sh[7:1] == addr_of(ADDR_B_BASE, q.strap_b);
  assign gc = q.sh[7:1] == pics_pkg::GCALL_ADDR &&
    q.sh[0] != pics_pkg::DIR_READ;
  assign cur_ptr = q.ptr[q.part];

  // ==========================================================
  // Next state
  always_comb begin
    next_q = q;
    next_q.reg_wr = 1'b0;
    next_q.reg_rd = 1'b0;
    next_q.rd_pend = 1'b0;
    next_q.scl_s = {q.scl_s[1:0], SCL};
    next_q.sda_s = {q.sda_s[1:0], SDA_IN};
    next_q.ra_s = {q.ra_s[1:0], RESET_A_N};
    next_q.rb_s = {q.rb_s[1:0], RESET_B_N};
    next_q.aa_s = {q.aa_s[1:0], ADDR_A};
    next_q.ab_s = {q.ab_s[1:0], ADDR_B};
    next_q.scl_f = scl_n;
    next_q.sda_f = sda_n;
    next_q.ra_f = flt(q.ra_s, q.ra_f);
    next_q.rb_f = flt(q.rb_s, q.rb_f);
    if (q.rd_pend) begin
      next_q.sh = (cur_ptr == pics_pkg::LOC_PAGE) ?
        8'(q.page[q.part]) : REG_RDATA;
    end
    if (start) begin
      next_q.st = pics_pkg::S_ADDR;
      next_q.cnt = '0;
      next_q.done = 1'b0;
      next_q.sda_oe = 1'b0;
    end else if (stop) begin
      next_q.st = pics_pkg::S_IDLE;
      next_q.sda_oe = 1'b0;
    end else begin
      unique case (q.st)
        pics_pkg::S_IDLE, pics_pkg::S_WAIT: begin
        end
        pics_pkg::S_ADDR, pics_pkg::S_WRITE: begin
          if (scl_rise) begin
            next_q.sh = {q.sh[6:0], sda_n};
            next_q.cnt = q.cnt + pics_pkg::BIT_STEP;
            next_q.done = q.cnt == pics_pkg::BIT_LAST;
          end else if (scl_fall && q.done) begin
            next_q.done = 1'b0;
            next_q.st = pics_pkg::S_ACK;
            next_q.sda_oe = 1'b1;
            if (q.st == pics_pkg::S_ADDR) begin
              next_q.rw = q.sh[0];
              next_q.gcall = gc;
              next_q.ptr_load = !q.sh[0];
              if (hit_a) begin
                next_q.part = pics_pkg::PART_A;
              end else if (hit_b) begin
                next_q.part = pics_pkg::PART_B;
              end else if (!gc) begin
                next_q.st = pics_pkg::S_WAIT;
                next_q.sda_oe = 1'b0;
              end
              if ((hit_a || hit_b) && q.sh[0]) begin
                next_q.reg_rd = q.ptr[next_q.part] != pics_pkg::LOC_PAGE;
                next_q.reg_addr = q.ptr[next_q.part];
                next_q.reg_part = next_q.part;
                next_q.reg_page = q.page[next_q.part];
                next_q.rd_pend = 1'b1;
              end
            end else if (!q.gcall) begin
              if (q.ptr_load) begin
                next_q.ptr[q.part] = q.sh[6:0];
                next_q.ptr_load = 1'b0;
              end else begin
                if (cur_ptr == pics_pkg::LOC_PAGE) begin
                  // 01h page 1, 00h page 0
                  if (q.sh == pics_pkg::PAGE1_VAL) begin
                    next_q.page[q.part] = 1'b1;
                  end else if (q.sh == pics_pkg::PAGE0_VAL) begin
                    next_q.page[q.part] = 1'b0;
                  end
                end else begin
                  next_q.reg_wr = 1'b1;
                  next_q.reg_addr = cur_ptr;
                  next_q.reg_wdata = q.sh;
                  next_q.reg_part = q.part;
                  next_q.reg_page = q.page[q.part];
                end
                next_q.ptr[q.part] = inc_sat(cur_ptr);
              end
            end
          end
        end
        pics_pkg::S_ACK: begin
          if (scl_fall) begin
            next_q.cnt = '0;
            if (q.rw == pics_pkg::DIR_READ) begin
              next_q.st = pics_pkg::S_READ;
              next_q.sda_oe = !q.sh[7];
            end else begin
              next_q.st = pics_pkg::S_WRITE;
              next_q.sda_oe = 1'b0;
            end
          end
        end
        pics_pkg::S_READ: begin
          if (scl_fall) begin
            if (q.cnt == pics_pkg::BIT_LAST) begin
              next_q.st = pics_pkg::S_RACK;
              next_q.sda_oe = 1'b0;
            end else begin
              next_q.sh = {q.sh[6:0], 1'b0};
              next_q.sda_oe = !q.sh[6];
            end
            next_q.cnt = q.cnt + pics_pkg::BIT_STEP;
          end
        end
        pics_pkg::S_RACK: begin
          if (scl_rise) begin
            next_q.done = !sda_n;
            if (!sda_n) begin
              next_q.ptr[q.part] = inc_sat(cur_ptr);
              next_q.reg_rd = inc_sat(cur_ptr) != pics_pkg::LOC_PAGE;
              next_q.reg_addr = inc_sat(cur_ptr);
              next_q.reg_part = q.part;
              next_q.reg_page = q.page[q.part];
              next_q.rd_pend = 1'b1;
            end
          end else if (scl_fall) begin
            next_q.done = 1'b0;
            next_q.cnt = '0;
            if (q.done) begin
              next_q.st = pics_pkg::S_READ;
              next_q.sda_oe = !q.sh[7];
            end else begin
              next_q.st = pics_pkg::S_WAIT;
            end
          end
        end
      endcase
    end
    if (!q.ra_f) begin
      next_q.page[pics_pkg::PART_A] = 1'b0;
      next_q.ptr[pics_pkg::PART_A] = pics_pkg::LOC_PAGE;
      next_q.strap_a = flt(q.aa_s, q.strap_a);
    end
    if (!q.rb_f) begin
      next_q.page[pics_pkg::PART_B] = 1'b0;
      next_q.ptr[pics_pkg::PART_B] = pics_pkg::LOC_PAGE;
      next_q.strap_b = flt(q.ab_s, q.strap_b);
    end
    next_q.sda_out = 1'b0;
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      q <= '0;
      q.scl_s <= pics_pkg::SYNC_IDLE;
      q.sda_s <= pics_pkg::SYNC_IDLE;
      q.scl_f <= 1'b1;
      q.sda_f <= 1'b1;
    end else begin
      q <= next_q;
    end
  end

  assign SDA_OUT = q.sda_out;
  assign SDA_OE = q.sda_oe;
  assign REG_WR = q.reg_wr;
  assign REG_RD = q.reg_rd;
  assign REG_PART = q.reg_part;
  assign REG_PAGE = q.reg_page;
  assign REG_ADDR = q.reg_addr;
  assign REG_WDATA = q.reg_wdata;

  // ==========================================================
  // Assertions
  default clocking @(posedge CLK); endclocking
  default disable iff (!ARST_N);
  logic adr_end;
  assign adr_end = q.st == pics_pkg::S_ADDR && q.done && scl_fall &&
    !start && !stop;
  a_sda_low_only: assert property (
    SDA_OUT == 1'b0) else $error("SDA driven high");
  a_page_reset: assert property (
    !q.ra_f |=> !q.page[pics_pkg::PART_A])
    else $error("page not cleared by reset");
  a_addr_ack: assert property (
    adr_end && (hit_a || hit_b) |=> SDA_OE && q.st == pics_pkg::S_ACK)
    else $error("matched address not acknowledged");
  a_addr_nack: assert property (
    adr_end && !hit_a && !hit_b && !gc |=> !SDA_OE [*2])
    else $error("unmatched address acknowledged");
  a_gcall_ack: assert property (
    adr_end && gc |=> SDA_OE && q.gcall)
    else $error("general call not acknowledged");
  a_start_addr: assert property (
    start |=> q.st == pics_pkg::S_ADDR && q.cnt == '0 && !SDA_OE)
    else $error("START did not restart address phase");
  a_stop_idle: assert property (
    stop |=> q.st == pics_pkg::S_IDLE && !SDA_OE)
    else $error("STOP did not idle the slave");
  a_page_one: assert property (
    q.st == pics_pkg::S_WRITE && q.done && scl_fall && !start &&
    !stop && !q.gcall && !q.ptr_load && q.part == pics_pkg::PART_A &&
    cur_ptr == pics_pkg::LOC_PAGE && q.sh == pics_pkg::PAGE1_VAL &&
    q.ra_f |=> q.page[pics_pkg::PART_A])
    else $error("page 1 not selected");
  a_wr_incr: assert property (
    REG_WR && $past(q.ra_f) && $past(q.rb_f) |->
    q.ptr[REG_PART] == inc_sat(REG_ADDR))
    else $error("pointer did not advance");
  a_no_wrap: assert property (
    REG_WR |-> REG_ADDR != pics_pkg::LOC_PAGE)
    else $error("burst wrapped into page select");
  a_rd_next: assert property (
    q.st == pics_pkg::S_RACK && scl_rise && !sda_n && !start && !stop
    |=> q.rd_pend ##1 q.done)
    else $error("acknowledged read not continued");

  c_write_burst: cover property (REG_WR ##[1:400] REG_WR);
  c_read_burst: cover property (REG_RD ##[1:400] REG_RD);
  c_page_one: cover property ($rose(q.page[pics_pkg::PART_B]));
  c_nack: cover property (adr_end && !hit_a && !hit_b && !gc);
endmodule
`default_nettype wire

//--- test/pics_master.sv
// Behavioural two-wire bus master that drives the control port.
`timescale 1ns/1ps
`default_nettype none
module pics_master (
  input wire logic clk,
  input wire logic sda_wire,
  output logic scl,
  output logic sda
);
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end
  // One step is two system clocks; a bus clock period is four steps.
  task automatic q(input int n);
    repeat (2 * n) @(negedge clk);
  endtask
  task automatic start();
    // Let the slave drop its acknowledge before the clock goes high.
    q(1);
    sda = 1'b1;
    q(2);
    scl = 1'b1;
    q(2);
    sda = 1'b0;
    q(2);
    scl = 1'b0;
  endtask
  task automatic stop();
    q(1);
    sda = 1'b0;
    q(1);
    scl = 1'b1;
    q(2);
    sda = 1'b1;
    q(2);
  endtask
  task automatic bit_io(input logic b, output logic r);
    q(1);
    sda = b;
    q(1);
    scl = 1'b1;
    q(2);
    r = sda_wire;
    scl = 1'b0;
  endtask
  task automatic xfer(input logic [7:0] tx, input logic ack_out,
                      output logic [7:0] rx, output logic ack_in);
    for (int i = 7; i >= 0; i--) begin
      bit_io(tx[i], rx[i]);
    end
    bit_io(ack_out, ack_in);
  endtask
endmodule
`default_nettype wire

//--- test/pics_slave_bench.sv
// Self-checking bench for the paged control-port slave.
`timescale 1ns/1ps
`default_nettype none
module pics_slave_bench;
  localparam logic [6:0] A1 = 7'h21;
  localparam logic [6:0] A0 = 7'h20;
  localparam logic [6:0] B0 = 7'h22;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic rst_a_n = 1'b0;
  logic rst_b_n = 1'b0;
  logic strap_a = 1'b1;
  logic strap_b = 1'b0;
  logic scl, m_sda, sdo, oe, wr_p, rd_p, part, page, ack, sda_wire;
  logic [6:0] addr;
  logic [7:0] wdata, rx;
  logic [7:0] rdata = 8'h00;
  logic [7:0] mem [0:511];
  int num_errors = 0;
  int cmp_count = 0;
  assign sda_wire = oe ? (m_sda & sdo) : m_sda;
  always #20 clk = ~clk;
  pics_slave u_dut (.CLK(clk), .ARST_N(arst_n), .RESET_A_N(rst_a_n),
    .RESET_B_N(rst_b_n), .ADDR_A(strap_a), .ADDR_B(strap_b), .SCL(scl),
    .SDA_IN(sda_wire), .SDA_OUT(sdo), .SDA_OE(oe), .REG_WR(wr_p),
    .REG_RD(rd_p), .REG_PART(part), .REG_PAGE(page), .REG_ADDR(addr),
    .REG_WDATA(wdata), .REG_RDATA(rdata));
  pics_master u_m (.clk(clk), .sda_wire(sda_wire), .scl(scl), .sda(m_sda));
  // ==========
  // Register file
  // Stores each write and answers a read request at the next falling clock edge.
  initial begin
    for (int i = 0; i < 512; i++) begin
      mem[i] = i[7:0];
    end
  end
  always @(negedge clk) begin
    if (wr_p) begin
      mem[{part, page, addr}] <= wdata;
    end
    if (rd_p) begin
      rdata <= mem[{part, page, addr}];
    end
  end
  // ==========
  // Checks and bus tasks
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test();
    $display("errors %0d comparisons %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic sel(input logic [6:0] dev, input logic dir, input logic na);
    u_m.start();
    u_m.xfer({dev, dir}, 1'b1, rx, ack);
    chk({7'h00, ack}, {7'h00, na});
    chk({7'h00, sdo}, 8'h00);
  endtask
  task automatic wr(input logic [6:0] dev, input logic [7:0] ptr,
                    input logic [7:0] d0, input logic [7:0] d1, input int n);
    sel(dev, 1'b0, 1'b0);
    u_m.xfer(ptr, 1'b1, rx, ack);
    chk({7'h00, ack}, 8'h00);
    for (int i = 0; i < n; i++) begin
      u_m.xfer(i == 0 ? d0 : d1, 1'b1, rx, ack);
      chk({7'h00, ack}, 8'h00);
    end
    u_m.stop();
  endtask
  task automatic rd(input logic [6:0] dev, input logic [7:0] ptr,
                    input logic [7:0] e0, input logic [7:0] e1, input int n);
    sel(dev, 1'b0, 1'b0);
    u_m.xfer(ptr, 1'b1, rx, ack);
    chk({7'h00, ack}, 8'h00);
    sel(dev, 1'b1, 1'b0);
    for (int i = 0; i < n; i++) begin
      u_m.xfer(8'hFF, i == n - 1, rx, ack);
      chk(rx, i == 0 ? e0 : e1);
    end
    u_m.stop();
  endtask
  // ==========
  // Main sequence
  initial begin
    repeat (3) @(negedge clk);
    arst_n = 1'b1;
    repeat (6) @(negedge clk);
    rst_a_n = 1'b1;
    rst_b_n = 1'b1;
    repeat (8) @(negedge clk);
    wr(A1, 8'h05, 8'hAA, 8'hBB, 2);
    rd(A1, 8'h05, 8'hAA, 8'hBB, 2);
    rd(B0, 8'h05, 8'h05, 8'h06, 2);
    wr(A1, 8'h00, 8'h01, 8'h00, 1);
    rd(A1, 8'h00, 8'h01, 8'h00, 1);
    wr(A1, 8'h05, 8'hCC, 8'h00, 1);
    rd(A1, 8'h05, 8'hCC, 8'h00, 1);
    rd(B0, 8'h00, 8'h00, 8'h00, 1);
    wr(A1, 8'h00, 8'h00, 8'h00, 1);
    rd(A1, 8'h05, 8'hAA, 8'h00, 1);
    wr(B0, 8'h7E, 8'h11, 8'h22, 2);
    rd(B0, 8'h7E, 8'h11, 8'h22, 2);
    wr(B0, 8'h00, 8'h01, 8'h00, 1);
    rd(B0, 8'h00, 8'h01, 8'h00, 1);
    rd(B0, 8'h05, 8'h85, 8'h00, 1);
    sel(7'h78, 1'b0, 1'b1);
    u_m.stop();
    sel(7'h00, 1'b0, 1'b0);
    u_m.stop();
    wr(A1, 8'h00, 8'h01, 8'h00, 1);
    strap_a = 1'b0;
    rst_a_n = 1'b0;
    repeat (8) @(negedge clk);
    rst_a_n = 1'b1;
    repeat (8) @(negedge clk);
    sel(A1, 1'b0, 1'b1);
    u_m.stop();
    rd(A0, 8'h00, 8'h00, 8'h00, 1);
    rd(A0, 8'h05, 8'hAA, 8'h00, 1);
    end_of_test();
  end
  initial begin
    repeat (60000) @(posedge clk);
    num_errors++;
    end_of_test();
  end
endmodule
`default_nettype wire
